// *** htf_frame_sync.sv ***
// Behaviour
// [R1] full-/low-speed mode keeps a free 1 ms frame timer for EOF limits
// [R2] high-speed mode keeps a 125 us microframe timer and derived 1 ms frame
// [R3] three consecutive missed microframe SOFs drop microframe sync
// [R4] high-speed upstream connectivity refused while unsynchronized, downstream always allowed
// [R5] no downstream signalling repeated upstream after EOF2 point
// [R6] SOFs in two consecutive microframes lock the microframe timer
// [R7] frame number plus one across consecutive SOFs marks zeroth microframe
// [R8] frame timer locks at zeroth SOF only once microframe timer locked
// [R9] every eighth microframe is a frame boundary, zeroth SOFs optional
// [R10] microframe sync loss drops frame sync in the same cycle
// [R11] in high-speed mode downstream full-speed SOFs only while frame locked, from next frame
// [R12] microframe number counts up on microframe timer, zero at frame boundary
// [R13] buffered periodic complete-split answers still allowed after sync loss
// [R14] sync loss aborts buffered periodic start-splits, ignores new ones
// [R15] sync loss stops SOFs, keep-alives and new periodic downstream work
// [R16] bulk/control start-splits and complete-splits keep being served
// [R17] pending bulk/control held, buffers kept until relock or buffer clear
// [R18] no downstream transactions while upstream port is suspended
// [R19] in high-speed mode normal downstream operation resumes only with both timers locked
// [R20] host keeps sending SOFs each microframe to hold lock
// [R21] downstream packet near EOF1 is abnormally terminated
// [R22] microframe length is a parameter counted in local clock cycles
module htf_frame_sync
  import htf_pkg::*;
#(
  parameter int unsigned UF_CYCLES   = UFRAME_CYCLES,
  parameter int unsigned FR_CYCLES   = FS_FRAME_CYCLES,
  parameter int unsigned EOF1_CYCLES = EOF1_MARGIN,
  parameter int unsigned EOF2_CYCLES = EOF2_MARGIN
) (
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RESET_N,
  // mode and upstream port state
  input  wire logic               HS_MODE,
  input  wire logic               UP_SUSPEND,
  // decoded high-speed SOF
  input  wire logic               SOF_VALID,
  input  wire logic [FRNUM_W-1:0] SOF_FRNUM,
  // connectivity requests
  input  wire logic               UP_CONN_REQ,
  input  wire logic               DN_CONN_REQ,
  // periodic split traffic
  input  wire logic               PER_SSPLIT_IN,
  input  wire logic               PER_CSPLIT_IN,
  input  wire logic               PER_CS_BUFFERED,
  // bulk/control split traffic
  input  wire logic               NP_SSPLIT_IN,
  input  wire logic               NP_CSPLIT_IN,
  input  wire logic               NP_PENDING,
  input  wire logic               CLEAR_TT_BUF,
  // downstream transmit status
  input  wire logic               DN_TX_ACTIVE,
  // sync status
  output logic                    UF_SYNCED,
  output logic                    FR_SYNCED,
  output logic [UFIDX_W-1:0]      UF_INDEX,
  output logic                    UF_TICK,
  output logic                    FR_TICK,
  // connectivity grants
  output logic                    UP_CONN_EN,
  output logic                    DN_CONN_EN,
  output logic                    UP_REPEAT_EN,
  // periodic control
  output logic                    PER_SS_ACCEPT,
  output logic                    PER_CS_ANSWER,
  output logic                    PER_ABORT,
  output logic                    PER_ISSUE_EN,
  // bulk/control control
  output logic                    NP_SS_ACCEPT,
  output logic                    NP_CS_ANSWER,
  output logic                    NP_ISSUE_EN,
  output logic                    NP_BUF_KEEP,
  // downstream frame generation
  output logic                    FS_SOF_GO,
  output logic                    KEEPALIVE_GO,
  output logic                    DN_TX_ABORT
);

  // ************************************************************
  // parameter checks
  // ************************************************************
  if (UF_CYCLES < 2 * (EOF1_CYCLES + 1) || UF_CYCLES >= (1 << CNT_W)) begin : g_uf_bad
    $error("htf_frame_sync: UF_CYCLES out of range");
  end
  if (FR_CYCLES < 2 * (EOF1_CYCLES + 1) || FR_CYCLES >= (1 << (CNT_W + 2))) begin : g_fr_bad
    $error("htf_frame_sync: FR_CYCLES out of range");
  end
  if (EOF2_CYCLES >= EOF1_CYCLES || EOF2_CYCLES == 0) begin : g_eof_bad
    $error("htf_frame_sync: EOF margins inconsistent");
  end

  localparam logic [CNT_W-1:0]   UF_LAST_CNT = CNT_W'(UF_CYCLES - 1);
  localparam logic [CNT_W-1:0]   UF_EOF1     = CNT_W'(UF_CYCLES - 1 - EOF1_CYCLES);
  localparam logic [CNT_W-1:0]   UF_EOF2     = CNT_W'(UF_CYCLES - 1 - EOF2_CYCLES);
  localparam logic [CNT_W+1:0]   FR_LAST_CNT = (CNT_W+2)'(FR_CYCLES - 1);
  localparam logic [CNT_W+1:0]   FR_EOF1     = (CNT_W+2)'(FR_CYCLES - 1 - EOF1_CYCLES);
  localparam logic [CNT_W+1:0]   FR_EOF2     = (CNT_W+2)'(FR_CYCLES - 1 - EOF2_CYCLES);

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ************************************************************
  // microframe timer
  // ************************************************************
  htf_state_e         state_reg;
  htf_state_e         state_next;
  logic [CNT_W-1:0]   uf_cnt_reg;
  logic [CNT_W+1:0]   fr_cnt_reg;
  logic [1:0]         miss_reg;
  logic               sof_seen_reg;
  logic [FRNUM_W-1:0] last_frnum_reg;
  logic [UFIDX_W-1:0] uf_idx_reg;
  logic               fr_armed_reg;
  logic               uf_end;
  logic               fr_end;
  logic               lost;
  logic               zeroth;
  logic               uf_lock;
  logic               fr_lock;

  // [R22] parametric microframe length
  assign uf_end = (uf_cnt_reg == UF_LAST_CNT);
  assign fr_end = (fr_cnt_reg == FR_LAST_CNT);

  // [R2] microframe timer aligns on SOF
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      uf_cnt_reg <= '0;
    end else if (SOF_VALID && HS_MODE) begin
      uf_cnt_reg <= '0;
    end else if (uf_end) begin
      uf_cnt_reg <= '0;
    end else begin
      uf_cnt_reg <= uf_cnt_reg + 1'b1;
    end
  end

  // [R3] count microframes without SOF
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      miss_reg     <= MISS_ZERO;
      sof_seen_reg <= 1'b0;
    end else if (SOF_VALID && HS_MODE) begin
      miss_reg     <= MISS_ZERO;
      sof_seen_reg <= 1'b1;
    end else if (uf_end) begin
      sof_seen_reg <= 1'b0;
      if (miss_reg != 2'(MISS_LIMIT)) begin
        miss_reg <= miss_reg + 1'b1;
      end
    end
  end

  assign lost   = uf_end && (miss_reg == 2'(MISS_LIMIT - 1)) && !SOF_VALID;
  // [R7] frame number step of one
  assign zeroth = SOF_VALID && sof_seen_reg && (SOF_FRNUM == last_frnum_reg + FRNUM_ONE);

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      last_frnum_reg <= '0;
    end else if (SOF_VALID) begin
      last_frnum_reg <= SOF_FRNUM;
    end
  end

  // ************************************************************
  // sync state machine
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      HTF_UNSYNC: begin
        if (SOF_VALID) begin
          state_next = HTF_ONE_SOF;
        end
      end
      HTF_ONE_SOF: begin
        // [R6] second consecutive SOF locks
        if (SOF_VALID && sof_seen_reg) begin
          state_next = zeroth ? HTF_FR_LOCK : HTF_UF_LOCK;
        end else if (SOF_VALID) begin
          state_next = HTF_ONE_SOF;
        end else if (uf_end && !sof_seen_reg) begin
          state_next = HTF_UNSYNC;
        end
      end
      HTF_UF_LOCK: begin
        // [R8] frame lock needs microframe lock
        if (lost) begin
          state_next = HTF_UNSYNC;
        end else if (zeroth) begin
          state_next = HTF_FR_LOCK;
        end
      end
      HTF_FR_LOCK: begin
        // [R10] both drop together
        if (lost) begin
          state_next = HTF_UNSYNC;
        end
      end
      default: begin
        state_next = HTF_UNSYNC;
      end
    endcase
    if (!HS_MODE) begin
      state_next = HTF_UNSYNC;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= HTF_UNSYNC;
    end else begin
      state_reg <= state_next;
    end
  end

  assign uf_lock = (state_next == HTF_UF_LOCK) || (state_next == HTF_FR_LOCK);
  assign fr_lock = (state_next == HTF_FR_LOCK);

  // ************************************************************
  // microframe index and frame timer
  // ************************************************************
  // [R12] index counts, zero at frame start
  // [R9] eight microframes per frame
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      uf_idx_reg <= UF_ZERO;
    end else if (zeroth && uf_lock) begin
      uf_idx_reg <= UF_ZERO;
    end else if (SOF_VALID || uf_end) begin
      uf_idx_reg <= (uf_idx_reg == UF_LAST) ? UF_ZERO : uf_idx_reg + 1'b1;
    end
  end

  assign UF_INDEX = uf_idx_reg;

  // [R1] free 1 ms timer at full speed
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fr_cnt_reg <= '0;
    end else if (HS_MODE && zeroth && uf_lock) begin
      fr_cnt_reg <= '0;
    end else if (fr_end) begin
      fr_cnt_reg <= '0;
    end else begin
      fr_cnt_reg <= fr_cnt_reg + 1'b1;
    end
  end

  // [R11] SOFs start at next frame boundary
  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      fr_armed_reg <= 1'b0;
    end else if (!fr_lock && HS_MODE) begin
      fr_armed_reg <= 1'b0;
    end else if (HS_MODE && zeroth && state_reg != HTF_FR_LOCK) begin
      fr_armed_reg <= 1'b1;
    end else if (fr_end || (HS_MODE && uf_end && uf_idx_reg == UF_LAST)) begin
      fr_armed_reg <= 1'b1;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic run_ok;
  logic past_eof2;
  logic past_eof1;

  // [R19] awake, and in high-speed mode both timers locked
  // [R18] nothing downstream in suspend
  assign run_ok    = (HS_MODE ? fr_lock : 1'b1) && !UP_SUSPEND;
  assign past_eof2 = HS_MODE ? (uf_cnt_reg >= UF_EOF2) : (fr_cnt_reg >= FR_EOF2);
  assign past_eof1 = HS_MODE ? (uf_cnt_reg >= UF_EOF1) : (fr_cnt_reg >= FR_EOF1);

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      UF_SYNCED <= 1'b0;
      FR_SYNCED <= 1'b0;
      UF_TICK   <= 1'b0;
      FR_TICK   <= 1'b0;
    end else begin
      UF_SYNCED <= uf_lock;
      FR_SYNCED <= fr_lock;
      UF_TICK   <= uf_lock && (SOF_VALID || uf_end);
      FR_TICK   <= HS_MODE ? (fr_lock && zeroth) || (fr_lock && uf_end && uf_idx_reg == UF_LAST)
                           : fr_end;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      UP_CONN_EN   <= 1'b0;
      DN_CONN_EN   <= 1'b0;
      UP_REPEAT_EN <= 1'b0;
    end else begin
      // [R4] upstream needs sync in high-speed mode
      UP_CONN_EN   <= UP_CONN_REQ && (HS_MODE ? uf_lock : 1'b1);
      DN_CONN_EN   <= DN_CONN_REQ;
      // [R5] cut repeating at EOF2
      UP_REPEAT_EN <= UP_CONN_REQ && (HS_MODE ? uf_lock : 1'b1) && !past_eof2;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      PER_SS_ACCEPT <= 1'b0;
      PER_CS_ANSWER <= 1'b0;
      PER_ABORT     <= 1'b0;
      PER_ISSUE_EN  <= 1'b0;
    end else begin
      // [R14] drop periodic start-splits
      PER_SS_ACCEPT <= PER_SSPLIT_IN && uf_lock;
      PER_ABORT     <= HS_MODE && !uf_lock && (state_reg == HTF_UF_LOCK || state_reg == HTF_FR_LOCK);
      // [R13] buffered answers survive
      PER_CS_ANSWER <= PER_CSPLIT_IN && PER_CS_BUFFERED;
      // [R15] no new periodic work
      PER_ISSUE_EN  <= run_ok;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      NP_SS_ACCEPT <= 1'b0;
      NP_CS_ANSWER <= 1'b0;
      NP_ISSUE_EN  <= 1'b0;
      NP_BUF_KEEP  <= 1'b0;
    end else begin
      // [R16] bulk/control always served
      NP_SS_ACCEPT <= NP_SSPLIT_IN;
      NP_CS_ANSWER <= NP_CSPLIT_IN;
      // [R17] hold pending until relock
      NP_ISSUE_EN  <= run_ok && !past_eof1;
      NP_BUF_KEEP  <= NP_PENDING && !CLEAR_TT_BUF;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      FS_SOF_GO    <= 1'b0;
      KEEPALIVE_GO <= 1'b0;
      DN_TX_ABORT  <= 1'b0;
    end else begin
      // [R15] SOFs and keep-alives gated
      FS_SOF_GO    <= run_ok && fr_armed_reg &&
                      (HS_MODE ? (uf_end && uf_idx_reg == UF_LAST) : fr_end);
      KEEPALIVE_GO <= run_ok && fr_armed_reg &&
                      (HS_MODE ? (uf_end && uf_idx_reg == UF_LAST) : fr_end);
      // [R21] abort near EOF1
      DN_TX_ABORT  <= DN_TX_ACTIVE && past_eof1;
    end
  end

endmodule : htf_frame_sync

// *** htf_frame_sync_checker.sv ***
module htf_frame_sync_checker
  import htf_pkg::*;
(
  // inputs watched
  input wire logic               SYS_CLK,
  input wire logic               RESET_N,
  input wire logic               HS_MODE,
  input wire logic               UP_SUSPEND,
  input wire logic               UP_CONN_REQ,
  input wire logic               DN_CONN_REQ,
  input wire logic               PER_SSPLIT_IN,
  input wire logic               PER_CSPLIT_IN,
  input wire logic               PER_CS_BUFFERED,
  input wire logic               NP_SSPLIT_IN,
  input wire logic               NP_CSPLIT_IN,
  input wire logic               NP_PENDING,
  input wire logic               CLEAR_TT_BUF,
  input wire logic               DN_TX_ACTIVE,
  // outputs watched
  input wire logic               UF_SYNCED,
  input wire logic               FR_SYNCED,
  input wire logic [UFIDX_W-1:0] UF_INDEX,
  input wire logic               UP_CONN_EN,
  input wire logic               DN_CONN_EN,
  input wire logic               PER_SS_ACCEPT,
  input wire logic               PER_CS_ANSWER,
  input wire logic               PER_ABORT,
  input wire logic               PER_ISSUE_EN,
  input wire logic               NP_SS_ACCEPT,
  input wire logic               NP_ISSUE_EN,
  input wire logic               FS_SOF_GO,
  input wire logic               UF_TICK,
  input wire logic               FR_TICK,
  input wire logic               UP_REPEAT_EN,
  input wire logic               NP_CS_ANSWER,
  input wire logic               NP_BUF_KEEP,
  input wire logic               KEEPALIVE_GO,
  input wire logic               DN_TX_ABORT
);
  logic [2:0] live_cnt_reg;
  // outputs meaningful after internal reset sync
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      live_cnt_reg <= 3'h0;
    end else if (live_cnt_reg != 3'h4) begin
      live_cnt_reg <= live_cnt_reg + 3'h1;
    end
  end
  wire logic live = (live_cnt_reg == 3'h4);
  wire logic hs = HS_MODE;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  chk_dn_conn_follow: assert property (live |-> DN_CONN_EN == $past(DN_CONN_REQ))
    else $error("downstream grant wrong");
  chk_up_conn_refuse: assert property (live && hs && $past(HS_MODE) && !$past(UF_SYNCED)
    && !UF_SYNCED |-> !UP_CONN_EN) else $error("upstream granted while unlocked");
  chk_frame_drop_same: assert property (live && hs && $past(HS_MODE) && $fell(UF_SYNCED)
    |-> !FR_SYNCED) else $error("frame lock outlived uframe lock");
  chk_per_abort_loss: assert property (live && hs && $past(HS_MODE) && $fell(UF_SYNCED)
    |-> ##[0:1] PER_ABORT) else $error("no periodic abort at loss");
  chk_per_ss_refuse: assert property (live && hs && $past(HS_MODE) && !$past(UF_SYNCED)
    && !UF_SYNCED |-> !PER_SS_ACCEPT) else $error("periodic start-split taken");
  chk_per_cs_answer: assert property (live |-> PER_CS_ANSWER ==
    ($past(PER_CSPLIT_IN) && $past(PER_CS_BUFFERED))) else $error("csplit answer wrong");
  chk_np_ss_accept: assert property (live |-> NP_SS_ACCEPT == $past(NP_SSPLIT_IN))
    else $error("bulk start-split not served");
  chk_suspend_quiet: assert property (live && $past(UP_SUSPEND) |->
    !PER_ISSUE_EN && !NP_ISSUE_EN && !FS_SOF_GO) else $error("issue while suspended");
  chk_sof_needs_lock: assert property (live && hs && $past(HS_MODE) && FS_SOF_GO |->
    FR_SYNCED || $fell(FR_SYNCED)) else $error("SOF without frame lock");
  chk_lock_index_zero: assert property (live && hs && $rose(FR_SYNCED) |->
    UF_INDEX == UF_ZERO) else $error("frame lock not at uframe 0");
  chk_repeat_cut_eof2: assert property (live && UF_TICK |-> !$past(UP_REPEAT_EN))
    else $error("repeating not cut before microframe end");
  chk_tx_abort_eof1: assert property (live && UF_TICK && $past(DN_TX_ACTIVE, 2)
    |-> $past(DN_TX_ABORT)) else $error("downstream packet not cut near EOF1");
  chk_index_step: assert property (live && UF_TICK && !FR_TICK
    |-> UF_INDEX == $past(UF_INDEX) + 3'h1) else $error("microframe index did not step");
  chk_ka_needs_lock: assert property (live && $past(HS_MODE) && !FR_SYNCED
    |-> !KEEPALIVE_GO) else $error("keep-alive without frame lock");
  chk_np_cs_answer: assert property (live |-> NP_CS_ANSWER == $past(NP_CSPLIT_IN))
    else $error("bulk complete-split not answered");
  chk_np_buf_keep: assert property (live |-> NP_BUF_KEEP ==
    ($past(NP_PENDING) && !$past(CLEAR_TT_BUF))) else $error("bulk buffer not kept");
endmodule : htf_frame_sync_checker

bind htf_frame_sync htf_frame_sync_checker chk (.*);

// *** htf_pkg.sv ***
package htf_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned UFRAME_NS       = 125_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned UFRAME_CYCLES   = UFRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned FS_FRAME_NS     = 1_000_000;
  localparam int unsigned FS_FRAME_CYCLES = FS_FRAME_NS / CLK_PERIOD_NS;
  localparam int unsigned UF_PER_FRAME    = 8;
  localparam int unsigned MISS_LIMIT      = 3;
  localparam int unsigned LOCK_SOFS       = 2;
  localparam int unsigned EOF1_MARGIN     = 2_500;
  localparam int unsigned EOF2_MARGIN     = 500;
  // ************************************************************
  // field widths
  // ************************************************************
  localparam int unsigned FRNUM_W = 11;
  localparam int unsigned UFIDX_W = 3;
  localparam int unsigned CNT_W   = 16;
  localparam logic [FRNUM_W-1:0] FRNUM_ONE = 11'h001;
  localparam logic [UFIDX_W-1:0] UF_ZERO   = 3'h0;
  localparam logic [UFIDX_W-1:0] UF_LAST   = 3'h7;
  localparam logic [1:0]         MISS_ZERO = 2'h0;
  // ************************************************************
  // sync state
  // ************************************************************
  typedef enum logic [1:0] {
    HTF_UNSYNC  = 2'b00,
    HTF_ONE_SOF = 2'b01,
    HTF_UF_LOCK = 2'b10,
    HTF_FR_LOCK = 2'b11
  } htf_state_e;
endpackage : htf_pkg

// *** htf_sof_host.sv ***
module htf_sof_host
  import htf_pkg::*;
#(
  parameter int unsigned UF = 64
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // host control and SOF out
  input  wire logic               en,
  output logic                    sof_valid,
  output logic [FRNUM_W-1:0]      sof_frnum
);
  logic [CNT_W-1:0]   cnt_reg;
  logic [UFIDX_W-1:0] uf_reg;
  logic [FRNUM_W-1:0] fr_reg;
  // first pair is uframe 7 then 0, across the 11-bit wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      uf_reg <= 3'h6;
      fr_reg <= 11'h7FF;
    end else if (cnt_reg == CNT_W'(UF - 1)) begin
      cnt_reg <= '0;
      uf_reg <= uf_reg + 3'h1;
      if (uf_reg == UF_LAST) begin
        fr_reg <= fr_reg + FRNUM_ONE;
      end
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sof_valid <= 1'b0;
    end else begin
      sof_valid <= en && (cnt_reg == CNT_W'(UF - 1));
    end
  end
  // number only meaningful with the pulse
  assign sof_frnum = sof_valid ? fr_reg : ~fr_reg;
endmodule : htf_sof_host

// *** hub_tt_frame_timer_sync_test.sv ***
module hub_tt_frame_timer_sync_test
  import htf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UF = 64;
  localparam int FR = 512;
  logic SYS_CLK, RESET_N, HS_MODE, UP_SUSPEND, SOF_VALID, UP_CONN_REQ, DN_CONN_REQ;
  logic PER_SSPLIT_IN, PER_CSPLIT_IN, PER_CS_BUFFERED, NP_SSPLIT_IN, NP_CSPLIT_IN;
  logic NP_PENDING, CLEAR_TT_BUF, DN_TX_ACTIVE, UF_SYNCED, FR_SYNCED, UF_TICK, FR_TICK;
  logic UP_CONN_EN, DN_CONN_EN, UP_REPEAT_EN, PER_SS_ACCEPT, PER_CS_ANSWER, PER_ABORT;
  logic PER_ISSUE_EN, NP_SS_ACCEPT, NP_CS_ANSWER, NP_ISSUE_EN, NP_BUF_KEEP;
  logic FS_SOF_GO, KEEPALIVE_GO, DN_TX_ABORT, host_en;
  logic [FRNUM_W-1:0] SOF_FRNUM;
  logic [UFIDX_W-1:0] UF_INDEX;
  logic [31:0]        rnd;
  int errors, tests_run, n_uf, n_fr, n_sof, c;
  htf_frame_sync #(.UF_CYCLES(UF), .FR_CYCLES(FR), .EOF1_CYCLES(8), .EOF2_CYCLES(2)) uut (.*);
  htf_sof_host #(.UF(UF)) host (.clk(SYS_CLK), .rst_n(RESET_N), .en(host_en),
    .sof_valid(SOF_VALID), .sof_frnum(SOF_FRNUM));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  function automatic int per(input int cycles, input int len);
    return cycles / len;
  endfunction : per
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  // count pulses over n cycles
  task automatic run(input int n);
    n_uf = 0;
    n_fr = 0;
    n_sof = 0;
    repeat (n) begin
      @(negedge SYS_CLK);
      n_uf += (UF_TICK === 1'b1);
      n_fr += (FR_TICK === 1'b1);
      n_sof += (FS_SOF_GO === 1'b1);
    end
  endtask : run
  task automatic wait_sync(input logic sel_uf, input logic want, input int lim);
    c = 0;
    while ((sel_uf ? UF_SYNCED : FR_SYNCED) !== want) begin
      @(negedge SYS_CLK);
      c++;
      if (c > lim) begin
        check("wait_bound", 1, 0);
        results();
      end
    end
  endtask : wait_sync
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end
  // random split and connect traffic
  always @(posedge SYS_CLK) begin
    #1;
    rnd = xs(rnd);
    {DN_CONN_REQ, PER_SSPLIT_IN, PER_CSPLIT_IN, PER_CS_BUFFERED, NP_SSPLIT_IN,
     NP_CSPLIT_IN, NP_PENDING, CLEAR_TT_BUF, DN_TX_ACTIVE} = rnd[8:0];
  end
  initial begin
    rnd = 32'h0000_0059;
    {DN_CONN_REQ, PER_SSPLIT_IN, PER_CSPLIT_IN, PER_CS_BUFFERED, NP_SSPLIT_IN,
     NP_CSPLIT_IN, NP_PENDING, CLEAR_TT_BUF, DN_TX_ACTIVE, UP_CONN_REQ, UP_SUSPEND} = '0;
    HS_MODE = 1'b1;
    host_en = 1'b1;
    RESET_N = 1'b0;
    repeat (12) @(posedge SYS_CLK);
    #1 RESET_N = 1'b1;
    UP_CONN_REQ = 1'b1;
    wait_sync(1'b0, 1'b1, 4 * UF);
    check("two_sof_wait", c > UF, 1);
    check("pair_uf_lock", UF_SYNCED, 1);
    check("zeroth_index", UF_INDEX, UF_ZERO);
    run(8 * UF);
    check("uf_ticks", n_uf, per(8 * UF, UF));
    check("fr_ticks", n_fr, per(8 * UF, 8 * UF));
    check("fs_sofs", n_sof, 1);
    check("frame_index", UF_INDEX, UF_ZERO);
    check("up_conn_on", UP_CONN_EN, 1);
    $display("test lock done");
    @(posedge SYS_CLK) #1 host_en = 1'b0;
    wait_sync(1'b1, 1'b0, 5 * UF);
    check("miss_window", (c > 2 * UF) && (c <= 3 * UF + 2), 1);
    check("fr_drop", FR_SYNCED, 0);
    run(8 * UF);
    check("fs_sofs_off", n_sof, 0);
    check("up_conn_off", UP_CONN_EN, 0);
    check("per_issue_off", PER_ISSUE_EN, 0);
    $display("test loss done");
    @(posedge SYS_CLK) #1 host_en = 1'b1;
    wait_sync(1'b1, 1'b1, 4 * UF);
    check("relock_two_sof", c >= UF, 1);
    wait_sync(1'b0, 1'b1, 10 * UF);
    run(2);
    check("per_issue_on", PER_ISSUE_EN, 1);
    $display("test relock done");
    @(posedge SYS_CLK) #1 UP_SUSPEND = 1'b1;
    run(3);
    check("susp_per", PER_ISSUE_EN, 0);
    check("susp_np", NP_ISSUE_EN, 0);
    @(posedge SYS_CLK) #1 UP_SUSPEND = 1'b0;
    run(3);
    check("resume_per", PER_ISSUE_EN, 1);
    $display("test suspend done");
    @(posedge SYS_CLK) #1 HS_MODE = 1'b0;
    run(2 * FR);
    run(4 * FR);
    check("fs_frames", n_fr, per(4 * FR, FR));
    check("fs_up_conn", UP_CONN_EN, 1);
    $display("test full speed done");
    results();
  end
endmodule : hub_tt_frame_timer_sync_test
